// [rtl/flash_status_pkg.sv]
// constants shared by the flash status polling controller
`default_nettype none
package flash_status_pkg;
   // status byte field positions
   localparam int unsigned POLL_BIT_POS = 7;
   localparam int unsigned TOGGLE_ONE_POS = 6;
   localparam int unsigned TIMING_LIMIT_POS = 5;
   localparam int unsigned ERASE_WINDOW_POS = 3;
   localparam int unsigned TOGGLE_TWO_POS = 2;
   // clock and bus cycle timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned STROBE_NS = 200;
   localparam int unsigned STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SECTOR_GAP_US = 50;
   localparam int unsigned SECTOR_GAP_CYCLES = SECTOR_GAP_US * 1000 / CLK_PERIOD_NS;
   // reset command data and the reset value of the data registers
   localparam logic [7:0] RESET_CMD = 8'hf0;
   localparam logic [7:0] RESET_VAL_BYTE = 8'h00;
   // outcomes of a status poll
   typedef enum logic [1:0] {
      RES_DONE = 2'b00,
      RES_FAIL = 2'b01,
      RES_ABORT = 2'b10
   } poll_result_t;
endpackage : flash_status_pkg
`default_nettype wire

// [rtl/flash_bus_if.sv]
// internal carrier between the sequencer and the strobe engine
`default_nettype none
interface flash_bus_if #(parameter int AW = 22);
   logic go;
   logic wr;
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic done;
   logic [7:0] rdata;
   modport seq (output go, output wr, output addr, output wdata, input done, input rdata);
   modport eng (input go, input wr, input addr, input wdata, output done, output rdata);
endinterface : flash_bus_if
`default_nettype wire

// [rtl/flash_cycle_engine.sv]
// one read or write strobe cycle on the flash pins
`default_nettype none
module flash_cycle_engine
   import flash_status_pkg::*;
#(
   parameter int AW = 22
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clk_en,
   flash_bus_if.eng bus,
   input wire logic [7:0] dq_sync,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [AW-1:0] addr_o,
   output logic [7:0] dq_o,
   output logic dq_oe
);
   typedef enum logic [1:0] {
      E_IDLE = 2'b00,
      E_STROBE = 2'b01,
      E_SAMPLE = 2'b10,
      E_END = 2'b11
   } eng_state_t;
   eng_state_t state_q;
   logic [3:0] cnt_q;
   logic wr_q;

   // strobe stays low for the set cycles plus two synchroniser stages, so read data has settled before sampling
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_q <= E_IDLE;
         cnt_q <= 4'h0;
         wr_q <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         addr_o <= '0;
         dq_o <= RESET_VAL_BYTE;
         dq_oe <= 1'b0;
         bus.done <= 1'b0;
         bus.rdata <= RESET_VAL_BYTE;
      end else if (clk_en) begin
         bus.done <= 1'b0;
         case (state_q)
            E_IDLE: begin
               if (bus.go) begin
                  wr_q <= bus.wr;
                  addr_o <= bus.addr;
                  dq_o <= bus.wdata;
                  dq_oe <= bus.wr;
                  ce_n <= 1'b0;
                  oe_n <= bus.wr;
                  we_n <= !bus.wr;
                  cnt_q <= 4'(STROBE_CYCLES + 2);
                  state_q <= E_STROBE;
               end
            end
            E_STROBE: begin
               if (cnt_q == 4'h1) state_q <= E_SAMPLE;
               else cnt_q <= cnt_q - 4'h1;
            end
            E_SAMPLE: begin
               // rising strobe ends the cycle; device advances toggle bits here
               bus.rdata <= dq_sync;
               oe_n <= 1'b1;
               we_n <= 1'b1;
               ce_n <= 1'b1;
               state_q <= E_END;
            end
            default: begin
               dq_oe <= 1'b0;
               bus.done <= 1'b1;
               state_q <= E_IDLE;
            end
         endcase
      end
   end
endmodule : flash_cycle_engine
`default_nettype wire

// [rtl/flash_status_poller.sv]
// host-side controller that polls program/erase status of a parallel flash
`default_nettype none
// Behaviour
// (R01) device pulls ready_busy_n low while program or erase is running
// (R02) device releases ready_busy_n when array data is readable or in standby
// (R03) ready_busy_n valid from rising edge of last write strobe
// (R04) toggle_bit_one flips every read while busy, stops when done
// (R05) toggle_bit_one valid from last write strobe and in erase window
// (R06) all-protected erase toggles about 100 us then returns to array reads
// (R07) protected-sector program toggles about 1 us then returns to array reads
// (R08) partially protected erase skips protected sectors silently
// (R09) toggle_bit_one stops changing in erase suspend
// (R10) toggle_bit_one toggles during program under erase suspend
// (R11) toggle_bit_two toggles on reads inside sectors selected for erase
// (R12) host reads status twice, unchanged toggle means finished
// (R13) toggling with timing_limit_bit high: recheck, still toggling means fail and reset
// (R14) host restarts double read after breaking off polling
// (R15) device sets timing_limit_bit when pulse limit exceeded
// (R16) programming a 0 back to 1 fails via timing_limit_bit
// (R17) after failure host writes reset command, device returns to reads
// (R18) erase_window_bit is 0 during add window, 1 once erase begins
// (R19) while erase_window_bit is 0 more sector erases are accepted
// (R20) host may skip erase_window_bit only if gaps stay under 50 us
// (R21) host checks erase_window_bit before and after each added sector erase
// (R22) host polls at valid_poll_address
// (R23) polling_bit reads inverse of written bit during program
// (R24) toggle bits change on each completed read strobe
module flash_status_poller
   import flash_status_pkg::*;
#(
   parameter int AW = 22
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // user side
   input wire logic start,
   input wire logic abort,
   input wire logic [AW-1:0] valid_poll_address,
   input wire logic check_window,
   output logic busy,
   output logic done,
   output logic [1:0] result,
   output logic [7:0] status_byte,
   output logic window_open,
   output logic ready_busy_q,
   // flash pins
   input wire logic ready_busy_n,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [AW-1:0] addr,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o,
   output logic dq_oe
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_READ1 = 3'b001,
      S_READ2 = 3'b010,
      S_DECIDE = 3'b011,
      S_RECHECK = 3'b100,
      S_RESET = 3'b101,
      S_WINDOW = 3'b110
   } poll_state_t;

   flash_bus_if #(.AW(AW)) bus_if ();

   poll_state_t state_q;
   logic [7:0] first_q;
   logic [7:0] prev_q;
   logic [AW-1:0] poll_addr_q;
   logic [7:0] dq_s1_q;
   logic [7:0] dq_s2_q;
   logic rb_s1_q;
   logic rb_s2_q;
   logic go_q;
   logic wr_q;
   logic [7:0] wdata_q;

   // pin inputs pass two flops before anything reads them
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         dq_s1_q <= 8'h00;
         dq_s2_q <= 8'h00;
         rb_s1_q <= 1'b1;
         rb_s2_q <= 1'b1;
      end else if (clk_en) begin
         dq_s1_q <= dq_i;
         dq_s2_q <= dq_s1_q;
         rb_s1_q <= ready_busy_n;
         rb_s2_q <= rb_s1_q;
      end
   end

   // ready/busy level is mirrored; open-drain wire is resolved outside
   always_ff @(posedge ref_clk) begin
      if (!nrst) ready_busy_q <= 1'b1;
      else if (clk_en) ready_busy_q <= rb_s2_q; // R01 R02 R03
   end

   assign bus_if.go = go_q;
   assign bus_if.wr = wr_q;
   assign bus_if.addr = poll_addr_q;
   assign bus_if.wdata = wdata_q;

   flash_cycle_engine #(.AW(AW)) u_eng (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .bus(bus_if.eng),
      .dq_sync(dq_s2_q),
      .ce_n(ce_n),
      .oe_n(oe_n),
      .we_n(we_n),
      .addr_o(addr),
      .dq_o(dq_o),
      .dq_oe(dq_oe)
   );

   // toggle-bit algorithm; every read is a full strobe so the device flips bits
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_q <= S_IDLE;
         first_q <= 8'h00;
         prev_q <= 8'h00;
         poll_addr_q <= '0;
         go_q <= 1'b0;
         wr_q <= 1'b0;
         wdata_q <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
         result <= RES_DONE;
         status_byte <= 8'h00;
         window_open <= 1'b0;
      end else if (clk_en) begin
         go_q <= 1'b0;
         done <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  poll_addr_q <= valid_poll_address; // R22
                  busy <= 1'b1;
                  wr_q <= 1'b0;
                  go_q <= 1'b1;
                  state_q <= check_window ? S_WINDOW : S_READ1;
               end
            end
            S_WINDOW: begin
               // single read for the sector-erase add window
               if (bus_if.done) begin
                  status_byte <= bus_if.rdata;
                  // window bit is always read, so no sector-gap guarantee is relied on
                  window_open <= !bus_if.rdata[ERASE_WINDOW_POS]; // R18 R19 R20 R21
                  busy <= 1'b0;
                  done <= 1'b1;
                  result <= RES_DONE;
                  state_q <= S_IDLE;
               end
            end
            S_READ1: begin
               // abort only between reads; next start begins at first read
               if (bus_if.done) begin
                  first_q <= bus_if.rdata;
                  if (abort) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                     result <= RES_ABORT; // R14
                     state_q <= S_IDLE;
                  end else begin
                     go_q <= 1'b1;
                     state_q <= S_READ2;
                  end
               end
            end
            S_READ2: begin
               if (bus_if.done) begin
                  prev_q <= bus_if.rdata;
                  status_byte <= bus_if.rdata;
                  state_q <= S_DECIDE;
               end
            end
            S_DECIDE: begin
               if (first_q[TOGGLE_ONE_POS] == prev_q[TOGGLE_ONE_POS]) begin
                  busy <= 1'b0; // R12
                  done <= 1'b1;
                  result <= RES_DONE;
                  state_q <= S_IDLE;
               end else if (prev_q[TIMING_LIMIT_POS]) begin
                  go_q <= 1'b1; // R13
                  state_q <= S_RECHECK;
               end else if (abort) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  result <= RES_ABORT; // R14
                  state_q <= S_IDLE;
               end else begin
                  go_q <= 1'b1;
                  state_q <= S_READ1; // R04 R24
               end
            end
            S_RECHECK: begin
               // compare the last read against one fresh read
               if (bus_if.done) begin
                  status_byte <= bus_if.rdata;
                  if (bus_if.rdata[TOGGLE_ONE_POS] == prev_q[TOGGLE_ONE_POS]) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                     result <= RES_DONE;
                     state_q <= S_IDLE;
                  end else begin
                     wr_q <= 1'b1;
                     wdata_q <= RESET_CMD; // R17
                     go_q <= 1'b1;
                     state_q <= S_RESET;
                  end
               end
            end
            default: begin
               if (bus_if.done) begin
                  wr_q <= 1'b0;
                  busy <= 1'b0;
                  done <= 1'b1;
                  result <= RES_FAIL; // R13 R15
                  state_q <= S_IDLE;
               end
            end
         endcase
      end
   end
endmodule : flash_status_poller
`default_nettype wire

// [tb/flash_poller_sva.sv]
// assertion checker for the flash status poller ports
`default_nettype none
module flash_poller_sva
   import flash_status_pkg::*;
#(
   parameter int AW = 22
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic check_window,
   input wire logic busy,
   input wire logic done,
   input wire logic [1:0] result,
   input wire logic [7:0] status_byte,
   input wire logic window_open,
   input wire logic ready_busy_q,
   input wire logic ready_busy_n,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] dq_o,
   input wire logic dq_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic win_q;
   logic [3:0] n_rd_q;
   // read strobes since start; a window check is a single read
   always_ff @(posedge ref_clk) begin
      if (!nrst || (start && !busy)) begin
         win_q <= nrst && check_window;
         n_rd_q <= 4'h0;
      end else if ($fell(oe_n) && n_rd_q != 4'hf) begin
         n_rd_q <= n_rd_q + 4'h1;
      end
   end
   // strobe state counts four cycles, then the sample cycle still holds the strobe low
   sequence rd_low_s;
      !oe_n [*5] ##1 oe_n;
   endsequence
   sequence wr_low_s;
      !we_n [*5] ##1 we_n;
   endsequence
   AST_READ_STROBE: assert property ($fell(oe_n) |-> rd_low_s)
      else $error("read strobe length wrong");
   AST_ADDR_HELD: assert property (!ce_n && !$past(ce_n) |-> $stable(addr))
      else $error("address moved inside a cycle");
   AST_WRITE_IS_RESET: assert property (!we_n |-> dq_oe && dq_o == RESET_CMD)
      else $error("write carries wrong data");
   AST_WRITE_THEN_FAIL: assert property ($fell(we_n) |-> wr_low_s ##[1:20] done && result == RES_FAIL)
      else $error("reset write not followed by fail");
   AST_TWO_READS: assert property (done && result == RES_DONE && !win_q |-> n_rd_q >= 2)
      else $error("finished after fewer than two reads");
   AST_FAIL_LIMIT: assert property (done && result == RES_FAIL |-> status_byte[TIMING_LIMIT_POS] && n_rd_q >= 3)
      else $error("fail without limit bit and recheck");
   AST_WINDOW: assert property (done && win_q |-> window_open == !status_byte[ERASE_WINDOW_POS])
      else $error("window flag wrong");
   AST_RB_SYNC: assert property (!ready_busy_n [*4] |-> !ready_busy_q)
      else $error("busy pin not followed");
endmodule : flash_poller_sva
bind flash_status_poller flash_poller_sva #(.AW(AW)) i_sva (.ref_clk(ref_clk), .nrst(nrst),
   .start(start), .check_window(check_window), .busy(busy), .done(done), .result(result),
   .status_byte(status_byte), .window_open(window_open), .ready_busy_q(ready_busy_q),
   .ready_busy_n(ready_busy_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
   .dq_o(dq_o), .dq_oe(dq_oe));
`default_nettype wire

// [tb/flash_dev_model.sv]
// behavioural flash answering status reads
`default_nettype none
module flash_dev_model (
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic rb_low
);
   timeunit 1ns;
   timeprecision 1ns;
   int reads_left = 0;
   logic fail_q = 1'b0;
   logic window_q = 1'b1;
   logic t_q = 1'b0;
   logic [7:0] stat;
   wire rd = !ce_n && !oe_n;
   wire wr = !ce_n && !we_n;
   wire active = (reads_left > 0) || fail_q;
   // status byte; the bus shows the inverse when not read, so stale samples fail
   // bit 3 carries the erase window, bit 2 the second toggle bit
   assign stat = {!active, t_q, fail_q, 1'b0, window_q, t_q, 2'b00};
   assign rd_data = rd ? stat : ~stat;
   assign rb_low = active;
   // toggles flip as the read ends, whichever strobe ends it
   always @(negedge rd) begin
      if (active) begin
         t_q <= ~t_q;
         if (!fail_q) reads_left <= reads_left - 1;
      end
   end
   // reset command clears a timing-limit failure
   always @(negedge wr) begin
      if (wr_data == 8'hf0) fail_q <= 1'b0;
   end
endmodule : flash_dev_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the flash status poller
`default_nettype none
module tb;
   import flash_status_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, nrst = 0, start = 0, abort = 0, check_window = 0;
   logic busy, done, window_open, ready_busy_q, ce_n, oe_n, we_n, dq_oe, rb_low;
   logic [1:0] result;
   logic [7:0] status_byte, dq_o, dev_dq;
   logic [21:0] addr;
   wire ready_busy_n = rb_low ? 1'b0 : 1'b1;
   int n_mismatch = 0;
   int comparisons = 0;
   // free-running clock, 100 ns period
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   flash_status_poller #(.AW(22)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1),
      .start(start), .abort(abort), .valid_poll_address(22'h12_3456),
      .check_window(check_window), .busy(busy), .done(done), .result(result),
      .status_byte(status_byte), .window_open(window_open), .ready_busy_q(ready_busy_q),
      .ready_busy_n(ready_busy_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
      .dq_i(dq_oe ? dq_o : dev_dq), .dq_o(dq_o), .dq_oe(dq_oe));
   flash_dev_model i_dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .wr_data(dq_o),
      .rd_data(dev_dq), .rb_low(rb_low));
   task automatic check(input logic [21:0] seen, input logic [21:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one poll from start to done, bounded
   task automatic poll(input int reads, input logic fail, input logic win, input logic ab);
      int n;
      i_dev.reads_left = reads;
      i_dev.fail_q = fail;
      check_window = win;
      abort = ab;
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      // a poll that never finished counts here as a mismatch
      check(done, 1'b1);
      check(busy, 1'b0);
      check(addr, 22'h12_3456);
   endtask : poll
   task automatic t_busy;
      i_dev.reads_left = 6;
      repeat (5) @(negedge ref_clk);
      check(ready_busy_q, 1'b0);
      poll(6, 1'b0, 1'b0, 1'b0);
      check(result, RES_DONE);
      check(ready_busy_q, 1'b1);
      check(status_byte[POLL_BIT_POS], 1'b1);
      poll(0, 1'b0, 1'b0, 1'b0);
      check(result, RES_DONE);
   endtask : t_busy
   task automatic t_fail;
      poll(0, 1'b1, 1'b0, 1'b0);
      check(result, RES_FAIL);
      check(status_byte[TIMING_LIMIT_POS], 1'b1);
      check(status_byte[POLL_BIT_POS], 1'b0);
      check(i_dev.fail_q, 1'b0);
   endtask : t_fail
   task automatic t_window;
      for (int w = 0; w < 2; w++) begin
         i_dev.window_q = w[0];
         poll(0, 1'b0, 1'b1, 1'b0);
         check(window_open, !w[0]);
      end
   endtask : t_window
   // abort mid-poll, then a fresh poll must start over
   task automatic t_abort;
      poll(100, 1'b0, 1'b0, 1'b1);
      check(result, RES_ABORT);
      poll(3, 1'b0, 1'b0, 1'b0);
      check(result, RES_DONE);
   endtask : t_abort
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   // reset, then the scenarios in turn
   initial begin
      repeat (10) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      t_busy;
      t_fail;
      t_window;
      t_abort;
      print_verdict;
   end
   // watchdog, well past the few hundred cycles the run needs
   initial begin
      #2000000;
      n_mismatch++;
      print_verdict;
   end
endmodule : tb
`default_nettype wire
